//--- hdl/semp_port.sv
`timescale 1ns/1ns
module semp_port #(
    parameter int RUN_DELAY = semp_pkg::RUN_DELAY_DEF
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic pll_lock,
    input wire logic power_down_n,
    input wire logic ram_8bit,
    input wire logic req_valid,
    output logic req_ready,
    input wire semp_pkg::semp_req_s req,
    output logic rsp_valid,
    output logic [semp_pkg::DATA_W-1:0] rsp_rdata,
    input wire logic [semp_pkg::DATA_W-1:0] mem_data_in,
    output semp_pkg::semp_pins_s pins,
    output logic pins_oe,
    output logic osc_enable,
    output logic run,
    input wire logic [semp_pkg::GPIO_W-1:0] gpio_in,
    input wire logic [semp_pkg::GPIO_W-1:0] gpio_drive,
    input wire logic [semp_pkg::GPIO_W-1:0] gpio_dir,
    input wire logic audio_alt_en,
    output logic [semp_pkg::GPIO_W-1:0] gpio_out,
    output logic [semp_pkg::GPIO_W-1:0] gpio_oe,
    output logic [semp_pkg::GPIO_W-1:0] gpio_level,
    output logic [semp_pkg::GPIO_W-2:0] audio_in
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Startup counter is 16 bits wide
    if (RUN_DELAY < 1 || RUN_DELAY > 65535)
    begin : g_bad_delay
        $error("RUN_DELAY out of range");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    localparam int SYNC_W = semp_pkg::DATA_W + semp_pkg::GPIO_W + 2;
    logic [SYNC_W-1:0] sync_out;
    logic [semp_pkg::DATA_W-1:0] data_sync;
    logic [semp_pkg::GPIO_W-1:0] gpio_sync;
    logic pdn_sync;
    logic lock_sync;

    semp_sync #(.WIDTH(SYNC_W)) u_sync (
        .mclk(mclk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .async_in({mem_data_in, gpio_in, ~power_down_n, pll_lock}),
        .sync_out(sync_out)
    );

    assign data_sync = sync_out[SYNC_W-1 -: semp_pkg::DATA_W];
    assign gpio_sync = sync_out[2 +: semp_pkg::GPIO_W];
    // Inverted so the synchroniser's reset level reads as not powered down
    assign pdn_sync = ~sync_out[1];
    assign lock_sync = sync_out[0];

    // ------------------------------------------------------------
    // Power-down and run state
    // ------------------------------------------------------------
    logic pd_reg;
    logic run_reg;
    logic [15:0] run_cnt_reg;

    // Power-down latches until reset, even if the pin is released
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
            pd_reg <= 1'b0;
        else if (clk_en && !pdn_sync)
            pd_reg <= 1'b1;
    end

    // Run rises once the PLL is locked and startup count elapsed
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            run_reg <= 1'b0;
            run_cnt_reg <= 16'h0000;
        end
        else if (clk_en)
        begin
            if (pd_reg || !lock_sync)
            begin
                run_reg <= 1'b0;
                run_cnt_reg <= 16'h0000;
            end
            else if (run_cnt_reg == 16'(RUN_DELAY - 1))
                run_reg <= 1'b1;
            else
                run_cnt_reg <= run_cnt_reg + 16'h0001;
        end
    end

    assign run = run_reg;
    assign osc_enable = !pd_reg;
    assign pins_oe = !pd_reg;

    // ------------------------------------------------------------
    // Memory cycle sequencer
    // ------------------------------------------------------------
    semp_pkg::semp_state_e state_reg;
    logic [semp_pkg::CNT_W-1:0] cnt_reg;
    logic write_reg;
    logic to_ram_reg;
    logic byte_mode_reg;
    logic [semp_pkg::DATA_W-1:0] wdata_reg;
    logic cnt_done;
    logic accept;

    assign cnt_done = (cnt_reg == '0);
    assign req_ready = (state_reg == semp_pkg::ST_IDLE) && run_reg && !pd_reg;
    assign accept = req_valid && req_ready && clk_en;

    logic in_cycle;
    logic strobe_phase;
    logic high_byte;
    logic cycle_end;
    semp_pkg::semp_pins_s pins_reg;

    // Phase decode shared by pins and response
    assign in_cycle = (state_reg != semp_pkg::ST_IDLE);
    assign strobe_phase = (state_reg == semp_pkg::ST_STROBE_LO) || (state_reg == semp_pkg::ST_STROBE_HI);
    assign high_byte = byte_mode_reg && ((state_reg == semp_pkg::ST_RECOVER)
        || (state_reg == semp_pkg::ST_STROBE_HI) || (state_reg == semp_pkg::ST_HOLD));
    assign cycle_end = cnt_done && ((state_reg == semp_pkg::ST_HOLD)
        || (state_reg == semp_pkg::ST_STROBE_HI && !write_reg));

    // Phase counts picked from the cycle kind; setup from the raw request, later phases from the latched kind
    function automatic logic [semp_pkg::CNT_W-1:0] phase_len(
        input semp_pkg::semp_state_e st,
        input logic wr,
        input logic bytes
    );
        int n;
        n = 1;
        case (st)
            semp_pkg::ST_SETUP: n = wr ? semp_pkg::CSWE_CYC : semp_pkg::CSOE_CYC;
            semp_pkg::ST_STROBE_LO: n = wr ? (bytes ? semp_pkg::WP8_CYC : semp_pkg::WP16_CYC)
                                           : (bytes ? semp_pkg::OELB_CYC : semp_pkg::POE_CYC);
            semp_pkg::ST_BYTE_GAP: n = semp_pkg::DH8_CYC;
            semp_pkg::ST_STROBE_HI: n = wr ? semp_pkg::WP8_CYC : semp_pkg::ACH_CYC;
            semp_pkg::ST_HOLD: n = wr ? semp_pkg::DH16_CYC : 1;
            default: n = 1;
        endcase
        return semp_pkg::CNT_W'(n - 1);
    endfunction

    // State and phase counter
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_reg <= semp_pkg::ST_IDLE;
            cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            if (pd_reg)
                state_reg <= semp_pkg::ST_IDLE;
            else
            begin
                if (!cnt_done)
                    cnt_reg <= cnt_reg - 1'b1;
                case (state_reg)
                    semp_pkg::ST_IDLE:
                        if (accept)
                        begin
                            state_reg <= semp_pkg::ST_SETUP;
                            cnt_reg <= phase_len(semp_pkg::ST_SETUP, req.write, 1'b0);
                        end
                    semp_pkg::ST_SETUP:
                        if (cnt_done)
                        begin
                            state_reg <= semp_pkg::ST_STROBE_LO;
                            cnt_reg <= phase_len(semp_pkg::ST_STROBE_LO, write_reg, byte_mode_reg);
                        end
                    semp_pkg::ST_STROBE_LO:
                        if (cnt_done && byte_mode_reg && write_reg)
                        begin
                            state_reg <= semp_pkg::ST_BYTE_GAP;
                            cnt_reg <= phase_len(semp_pkg::ST_BYTE_GAP, 1'b1, 1'b1);
                        end
                        else if (cnt_done && byte_mode_reg)
                        begin
                            state_reg <= semp_pkg::ST_STROBE_HI;
                            cnt_reg <= phase_len(semp_pkg::ST_STROBE_HI, 1'b0, 1'b1);
                        end
                        else if (cnt_done)
                        begin
                            state_reg <= semp_pkg::ST_HOLD;
                            cnt_reg <= phase_len(semp_pkg::ST_HOLD, write_reg, 1'b0);
                        end
                    semp_pkg::ST_BYTE_GAP:
                        if (cnt_done)
                        begin
                            // Byte select rises here, strobe waits the setup gap
                            state_reg <= semp_pkg::ST_RECOVER;
                            cnt_reg <= semp_pkg::CNT_W'(semp_pkg::AS_CYC - 1);
                        end
                    semp_pkg::ST_STROBE_HI:
                        if (cnt_done && write_reg)
                        begin
                            state_reg <= semp_pkg::ST_HOLD;
                            cnt_reg <= phase_len(semp_pkg::ST_HOLD, write_reg, 1'b1);
                        end
                        else if (cnt_done)
                            state_reg <= semp_pkg::ST_IDLE;
                    semp_pkg::ST_RECOVER:
                        // Byte select setup before the second write strobe
                        if (cnt_done)
                        begin
                            state_reg <= semp_pkg::ST_STROBE_HI;
                            cnt_reg <= phase_len(semp_pkg::ST_STROBE_HI, 1'b1, 1'b1);
                        end
                    default:
                        if (cnt_done)
                            state_reg <= semp_pkg::ST_IDLE;
                endcase
            end
        end
    end

    // Request latched at acceptance; ROM is never written
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            write_reg <= 1'b0;
            to_ram_reg <= 1'b0;
            byte_mode_reg <= 1'b0;
            wdata_reg <= semp_pkg::DATA_RST;
        end
        else if (accept)
        begin
            write_reg <= req.write && req.to_ram;
            to_ram_reg <= req.to_ram;
            byte_mode_reg <= req.to_ram && ram_8bit;
            wdata_reg <= req.wdata;
        end
    end

    // Registered pins: no strobe glitches, address moves only on a new request
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pins_reg.mem_addr <= semp_pkg::ADDR_RST;
            pins_reg.rom_select_n <= 1'b1;
            pins_reg.ram_select_n <= 1'b1;
            pins_reg.mem_read_enable_n <= 1'b1;
            pins_reg.ram_write_n <= 1'b1;
            pins_reg.ram_byte_select <= 1'b0;
            pins_reg.mem_data_out <= semp_pkg::DATA_RST;
            pins_reg.mem_data_oe <= 1'b0;
        end
        else if (clk_en)
        begin
            if (accept)
                pins_reg.mem_addr <= req.addr;
            pins_reg.rom_select_n <= !(in_cycle && !to_ram_reg);
            pins_reg.ram_select_n <= !(in_cycle && to_ram_reg);
            pins_reg.mem_read_enable_n <= !(strobe_phase && !write_reg);
            pins_reg.ram_write_n <= !(strobe_phase && write_reg);
            pins_reg.ram_byte_select <= high_byte;
            pins_reg.mem_data_oe <= in_cycle && write_reg;
            if (in_cycle && write_reg)
                pins_reg.mem_data_out <= {wdata_reg[15:8], high_byte ? wdata_reg[15:8] : wdata_reg[7:0]};
        end
    end

    assign pins = pins_reg;

    // Read data taken at the end of each strobe; 8-bit RAM fills one byte at a time
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= semp_pkg::DATA_RST;
        end
        else if (clk_en)
        begin
            rsp_valid <= cycle_end && !pd_reg;
            if (cnt_done && !write_reg && state_reg == semp_pkg::ST_STROBE_LO && byte_mode_reg)
                rsp_rdata[7:0] <= data_sync[7:0];
            else if (cnt_done && !write_reg && state_reg == semp_pkg::ST_STROBE_LO)
                rsp_rdata <= data_sync;
            else if (cnt_done && !write_reg && state_reg == semp_pkg::ST_STROBE_HI)
                rsp_rdata[15:8] <= data_sync[7:0];
        end
    end

    // General-purpose pins; audio inputs take over the upper three
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gpio_out <= '0;
            gpio_oe <= '0;
            gpio_level <= '0;
            audio_in <= '0;
        end
        else if (clk_en)
        begin
            gpio_level <= gpio_sync;
            gpio_out <= gpio_drive;
            gpio_oe <= pd_reg ? '0 : gpio_dir & ~{{(semp_pkg::GPIO_W-1){audio_alt_en}}, 1'b0};
            audio_in <= audio_alt_en ? gpio_sync[semp_pkg::GPIO_W-1:1] : '0;
        end
    end

endmodule

//--- common/semp_pkg.sv
package semp_pkg;

    // ------------------------------------------------------------
    // Widths and clock
    // ------------------------------------------------------------
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int GPIO_W = 4;
    localparam int CNT_W = 5;
    localparam int CLK_NS = 8;
    localparam int SYNC_CYC = 2;

    // ------------------------------------------------------------
    // Memory timing in ns and derived cycle counts (rounded up)
    // ------------------------------------------------------------
    localparam int T_RC_NS = 130;
    localparam int T_CSOE_NS = 45;
    localparam int T_POE_NS = 78;
    localparam int T_CSWE_NS = 40;
    localparam int T_WP16_NS = 104;
    localparam int T_DH16_NS = 10;
    localparam int T_OELB_NS = 20;
    localparam int T_ORB_NS = 26;
    localparam int T_ACH_NS = 45;
    localparam int T_WP8_NS = 20;
    localparam int T_DH8_NS = 20;
    localparam int T_AS_NS = 8;

    localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
    localparam int CSOE_CYC = (T_CSOE_NS + CLK_NS - 1) / CLK_NS;
    localparam int POE_CYC = (T_POE_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int CSWE_CYC = (T_CSWE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WP16_CYC = (T_WP16_NS + CLK_NS - 1) / CLK_NS;
    localparam int DH16_CYC = (T_DH16_NS + CLK_NS - 1) / CLK_NS;
    localparam int OELB_RAW = (T_OELB_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int ORB_RAW = (T_ORB_NS + CLK_NS - 1) / CLK_NS;
    localparam int OELB_CYC = (OELB_RAW > ORB_RAW) ? OELB_RAW : ORB_RAW;
    localparam int ACH_CYC = (T_ACH_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC;
    localparam int WP8_CYC = (T_WP8_NS + CLK_NS - 1) / CLK_NS;
    localparam int DH8_CYC = (T_DH8_NS + CLK_NS - 1) / CLK_NS;
    localparam int AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;

    // ------------------------------------------------------------
    // Reset values and startup
    // ------------------------------------------------------------
    localparam logic [ADDR_W-1:0] ADDR_RST = 25'h0000000;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
    localparam int RUN_DELAY_DEF = 16;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_SETUP = 3'b001,
        ST_STROBE_LO = 3'b010,
        ST_BYTE_GAP = 3'b011,
        ST_STROBE_HI = 3'b100,
        ST_HOLD = 3'b101,
        ST_RECOVER = 3'b110
    } semp_state_e;

    typedef struct packed
    {
        logic write;
        logic to_ram;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } semp_req_s;

    typedef struct packed
    {
        logic [ADDR_W-1:0] mem_addr;
        logic rom_select_n;
        logic ram_select_n;
        logic mem_read_enable_n;
        logic ram_write_n;
        logic ram_byte_select;
        logic [DATA_W-1:0] mem_data_out;
        logic mem_data_oe;
    } semp_pins_s;

endpackage

//--- hdl/semp_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for pin inputs; first stage feeds only the second
module semp_sync #(
    parameter int WIDTH = 1
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // Both stages freeze with the clock enable
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_reg <= '0;
            sync_out <= '0;
        end
        else if (clk_en)
        begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

//--- verification/semp_port_asserts.sv
`timescale 1ns/1ns
module semp_port_asserts (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic ram_8bit,
    input wire logic req_valid,
    input wire semp_pkg::semp_pins_s pins,
    input wire logic pins_oe,
    input wire logic osc_enable,
    input wire logic run
);
    // ----
    // Pin rules
    // ----
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    sequence ram_start_s;
        $fell(pins.ram_select_n);
    endsequence
    sequence byte_up_s;
        $rose(pins.ram_byte_select);
    endsequence
    cs_one_a: assert property (pins.rom_select_n || pins.ram_select_n)
        else $error("both selects low");
    drive_write_a: assert property (pins.mem_data_oe |-> !pins.ram_select_n && pins.mem_read_enable_n)
        else $error("data driven outside write");
    write_ram_a: assert property (!pins.ram_write_n |-> !pins.ram_select_n && pins.mem_data_oe)
        else $error("write strobe without ram");
    oe_sel_a: assert property (!pins.mem_read_enable_n |-> !(pins.rom_select_n && pins.ram_select_n))
        else $error("read enable with no select");
    byte_low_a: assert property (ram_start_s |-> !pins.ram_byte_select)
        else $error("ram cycle not low byte first");
    byte_up_a: assert property (byte_up_s |-> ram_8bit && !pins.ram_select_n)
        else $error("byte select outside 8-bit cycle");
    pd_float_a: assert property (!power_down_n [*4] |=> !pins_oe && !osc_enable)
        else $error("pins not floated in power down");
    run_late_a: assert property ($rose(reset_n) |-> !run [*4])
        else $error("run high too soon");
    addr_quiet_a: assert property ($changed(pins.mem_addr) |->
        $past(req_valid) || $past(req_valid, 2) || $past(req_valid, 3))
        else $error("address moved with no request");
endmodule
bind semp_port semp_port_asserts i_chk (.mclk(mclk), .reset_n(reset_n), .power_down_n(power_down_n),
    .ram_8bit(ram_8bit), .req_valid(req_valid), .pins(pins), .pins_oe(pins_oe),
    .osc_enable(osc_enable), .run(run));

//--- verification/semp_mem_model.sv
`timescale 1ns/1ns
module semp_mem_model (
    input wire logic mclk,
    input wire logic ram_8bit,
    input wire semp_pkg::semp_pins_s pins,
    input wire logic pins_oe,
    output logic [15:0] mem_data_in
);
    logic [7:0] ram_mem [0:511];
    logic [15:0] bus_last = 16'h0000;
    logic [8:0] idx;
    logic rd_on;
    // Byte index, byte select is the low bit on 8-bit parts
    assign idx = {pins.mem_addr[7:0], ram_8bit & pins.ram_byte_select};
    assign rd_on = !pins.mem_read_enable_n && pins_oe;
    // Bus level; a released bus flips every cycle so stale data never passes
    always_comb
    begin
        if (pins.mem_data_oe && pins_oe)
            mem_data_in = pins.mem_data_out;
        else if (rd_on && !pins.rom_select_n)
            mem_data_in = pins.mem_addr[15:0] ^ pins.mem_addr[24:9];
        else if (rd_on && !pins.ram_select_n && ram_8bit)
            mem_data_in = {~bus_last[15:8], ram_mem[idx]};
        else if (rd_on && !pins.ram_select_n)
            mem_data_in = {ram_mem[{idx[8:1], 1'b1}], ram_mem[idx]};
        else
            mem_data_in = ~bus_last;
    end
    // Last bus level
    always_ff @(posedge mclk)
        bus_last <= mem_data_in;
    // Store on the rising write strobe, data still held then
    always_ff @(posedge pins.ram_write_n)
    begin
        if (!pins.ram_select_n)
        begin
            ram_mem[idx] <= mem_data_in[7:0];
            if (!ram_8bit)
                ram_mem[{idx[8:1], 1'b1}] <= mem_data_in[15:8];
        end
    end
endmodule

//--- verification/testbench.sv
`timescale 1ns/1ns
module testbench;
    // ----
    // Bench
    // ----
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic power_down_n = 1'b1;
    logic ram_8bit = 1'b0;
    logic req_valid = 1'b0;
    logic audio_alt_en = 1'b0;
    logic clk_en = 1'b1;
    logic pll_lock = 1'b1;
    logic [3:0] gpio_in = 4'h0;
    semp_pkg::semp_req_s req = '0;
    semp_pkg::semp_pins_s pins;
    logic req_ready, rsp_valid, pins_oe, osc_enable, run;
    logic [15:0] rsp_rdata, mem_data_in;
    logic [3:0] gpio_out, gpio_oe, gpio_level;
    logic [2:0] audio_in;
    int failures = 0;
    int n_tests = 0;
    int n_rom = 0;
    semp_port i_dut (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en), .pll_lock(pll_lock),
        .power_down_n(power_down_n), .ram_8bit(ram_8bit), .req_valid(req_valid), .req_ready(req_ready),
        .req(req), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_data_in(mem_data_in), .pins(pins),
        .pins_oe(pins_oe), .osc_enable(osc_enable), .run(run), .gpio_in(gpio_in), .gpio_drive(4'h5),
        .gpio_dir(4'h0), .audio_alt_en(audio_alt_en), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
        .gpio_level(gpio_level), .audio_in(audio_in));
    semp_mem_model i_mem (.mclk(mclk), .ram_8bit(ram_8bit), .pins(pins), .pins_oe(pins_oe),
        .mem_data_in(mem_data_in));
    // Clock
    initial
        forever #4 mclk = ~mclk;
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Request held until ready is seen at an edge
    task automatic xfer(input logic wr, input logic rm, input logic [24:0] a, input logic [15:0] d,
        output logic [15:0] q, output int n);
        int k;
        req = '{write: wr, to_ram: rm, addr: a, wdata: d};
        req_valid = 1'b1;
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (req_ready !== 1'b1 && k < 50);
        n = 0;
        #1 req_valid = 1'b0;
        while (rsp_valid !== 1'b1 && n < 40)
        begin
            @(posedge mclk);
            n++;
        end
        q = rsp_rdata;
        if (!wr)
            chk("rsp_seen", 1, rsp_valid);
        #1;
    endtask
    task automatic wait_run();
        int k;
        k = 0;
        while (run !== 1'b1 && k < 200)
        begin
            @(posedge mclk);
            k++;
        end
        #1;
        chk("run_high", 1, run);
    endtask
    task automatic t_reset();
        cyc(4);
        reset_n = 1'b1;
        chk("idle_pins", 4'hf, {pins.rom_select_n, pins.ram_select_n, pins.mem_read_enable_n,
            pins.ram_write_n});
        chk("run_low", 0, run);
        wait_run();
    endtask
    // Top, bottom and a middle pattern of the word space
    task automatic t_rom();
        logic [24:0] al [3] = '{25'h0, 25'h1ffffff, 25'h0a5a5a5};
        logic [15:0] q;
        foreach (al[i])
        begin
            xfer(1'b0, 1'b0, al[i], 16'h0, q, n_rom);
            chk("rom_data", al[i][15:0] ^ al[i][24:9], q);
        end
    endtask
    task automatic t_ram(input logic m8);
        logic [15:0] q;
        int n;
        ram_8bit = m8;
        xfer(1'b1, 1'b1, 25'h3, 16'hc3a5, q, n);
        xfer(1'b1, 1'b1, 25'h4, 16'h7e81, q, n);
        xfer(1'b0, 1'b1, 25'h3, 16'h0, q, n);
        chk("ram_rd3", 16'hc3a5, q);
        xfer(0, 1, 25'h4, 16'h0, q, n);
        chk("ram_rd4", 16'h7e81, q);
        if (m8)
            chk("ram8_len", 1, n <= n_rom);
    endtask
    task automatic t_quiet();
        semp_pkg::semp_pins_s s;
        s = pins;
        cyc(10);
        chk("quiet", 1, pins === s);
    endtask
    task automatic t_gpio();
        gpio_in = 4'ha;
        audio_alt_en = 1'b1;
        cyc(5);
        chk("gpio_level", 4'ha, gpio_level);
        chk("audio_in", 3'h5, audio_in);
        chk("gpio_out", 4'h5, gpio_out);
        chk("gpio_oe", 4'h0, gpio_oe);
    endtask
    // Clock enable freezes state; lost lock drops run
    task automatic t_hold();
        clk_en = 1'b0;
        gpio_in = 4'h3;
        cyc(5);
        chk("frozen", 4'ha, gpio_level);
        clk_en = 1'b1;
        pll_lock = 1'b0;
        cyc(4);
        chk("run_unlock", 0, run);
        pll_lock = 1'b1;
        wait_run();
    endtask
    // Release the pin in power down, then leave it by reset
    task automatic t_pdown();
        power_down_n = 1'b0;
        cyc(6);
        chk("pd_float", 2'b00, {pins_oe, osc_enable});
        power_down_n = 1'b1;
        cyc(2);
        reset_n = 1'b0;
        t_reset();
        t_rom();
    endtask
    initial
    begin
        t_reset();
        t_rom();
        t_ram(1'b0);
        t_ram(1'b1);
        t_quiet();
        t_gpio();
        t_hold();
        t_pdown();
        final_report();
    end
    // Watchdog, well past the few hundred cycles needed
    initial
    begin
        #100000;
        failures++;
        final_report();
    end
endmodule
